// ==== logic/dif_decoder.v ====
`timescale 1ns/1ps
`include "dif_regs.vh"
module dif_decoder #(
    parameter integer TICK_CYC = `DIF_CLK_HZ / 1000000 * `DIF_SCAN_US
) (
    input  wire        clk_sys_i,
    input  wire        rst_b_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    input  wire [4:0]  term_i,
    input  wire        run_cmd_i,
    output reg         run3_o,
    output reg         stop3_o,
    output reg         dir3_o,
    output reg  [2:0]  preset_idx_o,
    output reg  [15:0] preset_freq_o,
    output reg  [15:0] preset_acc_o,
    output reg  [15:0] preset_dec_o,
    output reg         jog_fwd_o,
    output reg         jog_rev_o,
    output reg         jog_stop_o,
    output reg         acc_set2_o,
    output reg         ramp_hold_o,
    output reg         run_alt_o,
    output reg         freq_alt_o,
    output reg         rapid_stop_o,
    output reg         base_block_o,
    output reg         bb_resume_o,
    output reg  [15:0] bb_sweep_lo_o,
    output reg  [15:0] bb_sweep_hi_o,
    output reg         pid_dis_o,
    output reg         fault_rst_o,
    output reg         auto_seq_o,
    output reg  [15:0] ud_freq_o
);
    reg  [7:0]  ctrl_r;
    reg  [24:0] func_r;
    reg  [7:0]  scan_r;
    reg  [8:0]  step_r;
    reg  [15:0] fmax_r;
    reg  [15:0] kpad_r;
    reg  [15:0] pfrq_r [0:7];
    reg  [31:0] pacc_r [0:7];
    reg  [13:0] tick_cnt_r;
    reg         tick_r;
    reg  [4:0]  s1_r;
    reg  [4:0]  s2_r;
    reg  [4:0]  s3_r;
    wire [4:0]  lvl_r;
    reg  [31:0] rd_nxt;
    reg         hit_nxt;
    reg  [10:0] hold_cnt_r;
    reg  [6:0]  ramp_cnt_r;
    reg         up_d_r;
    reg         dn_d_r;
    reg         run_d_r;
    reg         bb_d_r;
    reg         rst_d_r;
    reg         ud_off_r;
    reg  [16:0] up_sum;
    integer     k;

    wire        three_w = ctrl_r[`DIF_RUNMODE_LSB+1:`DIF_RUNMODE_LSB] == `DIF_RUN_3WIRE;
    wire [1:0]  keep    = ctrl_r[`DIF_KEEP_LSB+1:`DIF_KEEP_LSB];
    // Polarity lives in its own register so all five bits fit
    reg  [4:0]  pol_r;

    function fn_act;
        input [4:0]  code;
        input [24:0] funcs;
        input [4:0]  lvl;
        input        tw;
        integer      i;
        begin
            fn_act = 1'b0;
            for (i = 0; i < 5; i = i + 1) begin
                if (funcs[i*5 +: 5] == code && lvl[i] && !(tw && i < 3)) begin
                    fn_act = 1'b1;
                end
            end
        end
    endfunction

    wire f_ps4 = fn_act(5'h04, func_r, lvl_r, three_w);
    wire f_ps2 = fn_act(5'h03, func_r, lvl_r, three_w);
    wire f_ps1 = fn_act(5'h02, func_r, lvl_r, three_w);
    wire f_jf  = fn_act(5'h06, func_r, lvl_r, three_w);
    wire f_jr  = fn_act(5'h07, func_r, lvl_r, three_w);
    wire f_up  = fn_act(5'h08, func_r, lvl_r, three_w);
    wire f_dn  = fn_act(5'h09, func_r, lvl_r, three_w);
    wire f_acc = fn_act(5'h0A, func_r, lvl_r, three_w);
    wire f_hld = fn_act(5'h0B, func_r, lvl_r, three_w);
    wire f_run = fn_act(5'h0C, func_r, lvl_r, three_w);
    wire f_frq = fn_act(5'h0D, func_r, lvl_r, three_w);
    wire f_es  = fn_act(5'h0E, func_r, lvl_r, three_w);
    wire f_bb  = fn_act(5'h0F, func_r, lvl_r, three_w);
    wire f_pid = fn_act(5'h10, func_r, lvl_r, three_w);
    wire f_rst = fn_act(5'h11, func_r, lvl_r, three_w);
    wire f_seq = fn_act(5'h12, func_r, lvl_r, three_w);
    wire [2:0] idx = {f_ps4, f_ps2, f_ps1};

    wire acc_ph = psel_i && penable_i && pready_o;
    wire wr_en  = acc_ph && pwrite_i;

    // Scan tick divider
    always @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            tick_cnt_r <= 14'h0000;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == TICK_CYC[13:0] - 14'h0001) begin
            tick_cnt_r <= 14'h0000;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 14'h0001;
            tick_r     <= 1'b0;
        end
    end

    // Pin synchroniser, a change is seen once stages two and three agree
    always @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            s1_r <= 5'h00;
            s2_r <= 5'h00;
            s3_r <= 5'h00;
        end else begin
            s1_r <= term_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_deb
            reg [7:0] cnt_r;
            reg       lvl_q;
            wire      pin = s3_r[g] ^ pol_r[g];
            assign lvl_r[g] = lvl_q;
            always @(posedge clk_sys_i) begin
                if (!rst_b_i) begin
                    cnt_r <= 8'h00;
                    lvl_q <= 1'b0;
                end else if (s2_r[g] != s3_r[g] || pin == lvl_q) begin
                    cnt_r <= 8'h00;
                end else if (tick_r) begin
                    // Shorter pulses restart the count and are dropped as noise
                    if (cnt_r + 8'h01 >= scan_r) begin
                        cnt_r <= 8'h00;
                        lvl_q <= pin;
                    end else begin
                        cnt_r <= cnt_r + 8'h01;
                    end
                end
            end
        end
    endgenerate

    // Register read mux
    always @* begin
        rd_nxt  = 32'h0000_0000;
        hit_nxt = 1'b1;
        case (paddr_i)
            `DIF_CTRL_OFS: rd_nxt = {19'h0_0000, pol_r, ctrl_r[3:0], 4'h0} >> 4;
            `DIF_FUNC_OFS: rd_nxt = {7'h00, func_r};
            `DIF_SCAN_OFS: rd_nxt = {24'h00_0000, scan_r};
            `DIF_STEP_OFS: rd_nxt = {23'h00_0000, step_r};
            `DIF_FMAX_OFS: rd_nxt = {16'h0000, fmax_r};
            `DIF_STAT_OFS: rd_nxt = {24'h00_0000, ud_off_r, rapid_stop_o, idx, 3'h0} |
                                    {27'h000_0000, lvl_r};
            `DIF_FREQ_OFS: rd_nxt = {16'h0000, ud_freq_o};
            `DIF_KPAD_OFS: rd_nxt = {16'h0000, kpad_r};
            default: begin
                if (paddr_i[7:5] == 3'h2 && paddr_i[1:0] == 2'h0) begin
                    rd_nxt = {16'h0000, pfrq_r[paddr_i[4:2]]};
                end else if (paddr_i[7:5] == 3'h3 && paddr_i[1:0] == 2'h0) begin
                    rd_nxt = pacc_r[paddr_i[4:2]];
                end else begin
                    hit_nxt = 1'b0;
                end
            end
        endcase
    end

    // APB slave, one wait state per transfer
    always @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= psel_i && penable_i && !pready_o;
            pslverr_o <= psel_i && penable_i && !pready_o && !hit_nxt;
            prdata_o  <= (psel_i && !pwrite_i) ? rd_nxt : 32'h0000_0000;
        end
    end

    always @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ctrl_r <= `DIF_CTRL_RST;
            pol_r  <= 5'h00;
            func_r <= `DIF_FUNC_RST;
            scan_r <= `DIF_SCAN_RST;
            step_r <= `DIF_STEP_RST;
            fmax_r <= `DIF_FMAX_RST;
            for (k = 0; k < 8; k = k + 1) begin
                pfrq_r[k] <= 16'h0000;
                pacc_r[k] <= 32'h0000_0000;
            end
        end else if (wr_en) begin
            case (paddr_i)
                `DIF_CTRL_OFS: begin
                    ctrl_r <= {4'h0, pwdata_i[3:0]};
                    pol_r  <= pwdata_i[8:4];
                end
                `DIF_FUNC_OFS: func_r <= pwdata_i[24:0];
                `DIF_SCAN_OFS: begin
                    if (pwdata_i[7:0] != 8'h00 && pwdata_i[7:0] <= `DIF_SCAN_MAX) begin
                        scan_r <= pwdata_i[7:0];
                    end
                end
                `DIF_STEP_OFS: begin
                    if (pwdata_i[8:0] <= `DIF_STEP_MAX && pwdata_i[31:9] == 23'h00_0000) begin
                        step_r <= pwdata_i[8:0];
                    end
                end
                `DIF_FMAX_OFS: fmax_r <= pwdata_i[15:0];
                default: begin
                    if (paddr_i[7:5] == 3'h2 && paddr_i[1:0] == 2'h0) begin
                        pfrq_r[paddr_i[4:2]] <= pwdata_i[15:0];
                    end else if (paddr_i[7:5] == 3'h3 && paddr_i[1:0] == 2'h0) begin
                        pacc_r[paddr_i[4:2]] <= pwdata_i;
                    end
                end
            endcase
        end
    end

    // Up/down frequency engine
    wire stop_ev  = run_d_r && !run_cmd_i;
    wire up_edge  = f_up && !up_d_r;
    wire dn_edge  = f_dn && !dn_d_r;
    wire held     = hold_cnt_r == `DIF_HOLD_MS;
    wire ramp_ev  = held && tick_r && ramp_cnt_r == `DIF_RAMP_MS - 1;
    wire ud_ok    = !ud_off_r && !f_hld;
    wire [15:0] stp = {7'h00, step_r};

    always @* begin
        up_sum = {1'b0, ud_freq_o} + {1'b0, stp};
    end

    always @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ud_freq_o  <= 16'h0000;
            kpad_r     <= 16'h0000;
            hold_cnt_r <= 11'h000;
            ramp_cnt_r <= 7'h00;
            up_d_r     <= 1'b0;
            dn_d_r     <= 1'b0;
            run_d_r    <= 1'b0;
            ud_off_r   <= 1'b0;
        end else begin
            up_d_r  <= f_up;
            dn_d_r  <= f_dn;
            run_d_r <= run_cmd_i;
            if (f_up == f_dn) begin
                hold_cnt_r <= 11'h000;
            end else if (tick_r && !held) begin
                hold_cnt_r <= hold_cnt_r + 11'h001;
            end
            if (!held || ramp_ev) begin
                ramp_cnt_r <= 7'h00;
            end else if (tick_r) begin
                ramp_cnt_r <= ramp_cnt_r + 7'h01;
            end
            if (run_cmd_i && !run_d_r) begin
                ud_off_r <= 1'b0;
            end
            if (stop_ev) begin
                if (keep == `DIF_KEEP_ZERO) begin
                    ud_freq_o <= 16'h0000;
                end else begin
                    kpad_r <= ud_freq_o;
                    ud_off_r <= keep == `DIF_KEEP_HOLD;
                end
            end else if (ud_ok && f_up && !f_dn && (up_edge || ramp_ev)) begin
                ud_freq_o <= (up_sum > {1'b0, fmax_r}) ? fmax_r : up_sum[15:0];
            end else if (ud_ok && f_dn && !f_up && (dn_edge || ramp_ev)) begin
                ud_freq_o <= (ud_freq_o < stp) ? 16'h0000 : ud_freq_o - stp;
            end
            if (wr_en && paddr_i == `DIF_KPAD_OFS && !stop_ev) begin
                kpad_r <= pwdata_i[15:0];
            end
        end
    end

    // Decoded command outputs
    always @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            run3_o        <= 1'b0;
            stop3_o       <= 1'b0;
            dir3_o        <= 1'b0;
            preset_idx_o  <= 3'h0;
            preset_freq_o <= 16'h0000;
            preset_acc_o  <= 16'h0000;
            preset_dec_o  <= 16'h0000;
            jog_fwd_o     <= 1'b0;
            jog_rev_o     <= 1'b0;
            jog_stop_o    <= 1'b0;
            acc_set2_o    <= 1'b0;
            ramp_hold_o   <= 1'b0;
            run_alt_o     <= 1'b0;
            freq_alt_o    <= 1'b0;
            rapid_stop_o  <= 1'b0;
            base_block_o  <= 1'b0;
            bb_resume_o   <= 1'b0;
            bb_sweep_lo_o <= 16'h0000;
            bb_sweep_hi_o <= 16'h0000;
            pid_dis_o     <= 1'b0;
            fault_rst_o   <= 1'b0;
            auto_seq_o    <= 1'b0;
            bb_d_r        <= 1'b0;
            rst_d_r       <= 1'b0;
        end else begin
            run3_o        <= three_w && lvl_r[0];
            stop3_o       <= three_w && lvl_r[1];
            dir3_o        <= three_w && lvl_r[2];
            preset_idx_o  <= idx;
            preset_freq_o <= pfrq_r[idx];
            preset_acc_o  <= pacc_r[idx][15:0];
            preset_dec_o  <= pacc_r[idx][31:16];
            jog_fwd_o     <= f_jf && !f_jr;
            jog_rev_o     <= f_jr && !f_jf;
            jog_stop_o    <= f_jf && f_jr;
            acc_set2_o    <= f_acc || f_es;
            ramp_hold_o   <= f_hld;
            run_alt_o     <= f_run;
            freq_alt_o    <= f_frq;
            // Latched until a fresh run request once the input is gone
            if (f_es) begin
                rapid_stop_o <= 1'b1;
            end else if (run_cmd_i && !run_d_r) begin
                rapid_stop_o <= 1'b0;
            end
            bb_d_r        <= f_bb;
            base_block_o  <= f_bb;
            bb_resume_o   <= bb_d_r && !f_bb;
            bb_sweep_lo_o <= (kpad_r < `DIF_BB_OFS) ? 16'h0000 : kpad_r - `DIF_BB_OFS;
            bb_sweep_hi_o <= kpad_r + `DIF_BB_OFS;
            pid_dis_o     <= f_pid;
            rst_d_r       <= f_rst;
            fault_rst_o   <= f_rst && !rst_d_r;
            auto_seq_o    <= f_seq;
        end
    end
endmodule // dif_decoder

// ==== logic/dif_regs.vh ====
`ifndef DIF_REGS_VH
`define DIF_REGS_VH
// Register byte offsets
`define DIF_CTRL_OFS    8'h00
`define DIF_FUNC_OFS    8'h04
`define DIF_SCAN_OFS    8'h08
`define DIF_STEP_OFS    8'h0C
`define DIF_FMAX_OFS    8'h10
`define DIF_STAT_OFS    8'h14
`define DIF_FREQ_OFS    8'h18
`define DIF_KPAD_OFS    8'h1C
`define DIF_PFRQ_OFS    8'h40
`define DIF_PACC_OFS    8'h60
// CTRL fields
`define DIF_RUNMODE_LSB 0
`define DIF_KEEP_LSB    2
`define DIF_POL_LSB     4
// Reset values
`define DIF_CTRL_RST    8'h00
`define DIF_FUNC_RST    25'h000_0000
`define DIF_SCAN_RST    8'h01
`define DIF_STEP_RST    9'h001
`define DIF_FMAX_RST    16'h1770
// Limits and codes
`define DIF_STEP_MAX    9'h1F4
`define DIF_SCAN_MAX    8'hC8
`define DIF_RUN_3WIRE   2'h2
`define DIF_KEEP_HOLD   2'h0
`define DIF_KEEP_ZERO   2'h1
`define DIF_BB_OFS      16'h01F4
// Timing
`define DIF_CLK_HZ      10000000
`define DIF_SCAN_US     1000
`define DIF_HOLD_MS     2000
`define DIF_RAMP_MS     100
`endif

// ==== dv/dif_switch_model.sv ====
`timescale 1ns/1ps
module dif_switch_model #(
    parameter integer CHATTER_CYC = 2
) (
    input  wire       clk_i,
    input  wire [4:0] press_i,
    output reg  [4:0] term_o
);
    reg     [4:0] want_r;
    reg     [4:0] mask_r;
    integer       left_r;
    initial begin
        term_o = 5'h00;
        want_r = 5'h00;
        mask_r = 5'h00;
        left_r = 0;
    end
    // Contacts chatter on each change, shorter than one debounce window
    always @(posedge clk_i) begin
        if (press_i != want_r) begin
            mask_r <= press_i ^ want_r;
            want_r <= press_i;
            left_r <= CHATTER_CYC;
            term_o <= term_o ^ press_i ^ want_r;
        end else if (left_r > 0) begin
            left_r <= left_r - 1;
            term_o <= (left_r == 1) ? want_r : term_o ^ mask_r;
        end
    end
endmodule // dif_switch_model

// ==== dv/dif_decoder_props.sv ====
`timescale 1ns/1ps
module dif_decoder_props (
    input wire        clk_sys_i,
    input wire        rst_b_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pready_o,
    input wire        run_cmd_i,
    input wire        jog_fwd_o,
    input wire        jog_rev_o,
    input wire        jog_stop_o,
    input wire        acc_set2_o,
    input wire        rapid_stop_o,
    input wire        base_block_o,
    input wire        bb_resume_o,
    input wire [15:0] bb_sweep_lo_o,
    input wire [15:0] bb_sweep_hi_o,
    input wire        fault_rst_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    jog_stop_excl_a: assert property (jog_stop_o |-> !jog_fwd_o && !jog_rev_o)
        else $error("jog stop with a jog direction");
    apb_answer_a: assert property (psel_i && $rose(penable_i) |=> pready_o)
        else $error("no ready after access");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    rapid_latch_a: assert property (rapid_stop_o && !run_cmd_i |=> rapid_stop_o)
        else $error("rapid stop left without run");
    rapid_decel_a: assert property ($rose(rapid_stop_o) |-> acc_set2_o)
        else $error("rapid stop without second ramp");
    bb_release_a: assert property ($fell(base_block_o) |-> ##[0:2] bb_resume_o)
        else $error("no resume after coast release");
    resume_idle_a: assert property (bb_resume_o |-> !base_block_o ##1 !bb_resume_o)
        else $error("resume not a single pulse");
    fault_pulse_a: assert property (fault_rst_o |=> !fault_rst_o)
        else $error("fault reset not a pulse");
    sweep_span_a: assert property (bb_sweep_lo_o != 16'h0000 |->
        bb_sweep_hi_o == bb_sweep_lo_o + 16'h03E8) else $error("sweep span wrong");
    cover property (bb_resume_o);
    cover property (jog_stop_o);
    cover property ($fell(rapid_stop_o));
endmodule // dif_decoder_props
bind dif_decoder dif_decoder_props u_dif_decoder_props (.clk_sys_i, .rst_b_i, .psel_i,
    .penable_i, .pready_o, .run_cmd_i, .jog_fwd_o, .jog_rev_o, .jog_stop_o, .acc_set2_o,
    .rapid_stop_o, .base_block_o, .bb_resume_o, .bb_sweep_lo_o, .bb_sweep_hi_o, .fault_rst_o);

// ==== dv/dif_decoder_tb.sv ====
`timescale 1ns/1ps
`include "dif_regs.vh"
module dif_decoder_tb;
    localparam integer TICK = 10;
    localparam [29:0] LV = {5'h12, 5'h10, 5'h0D, 5'h0C, 5'h0B, 5'h0A};
    logic clk_sys_i = 1'b0, rst_b_i = 1'b0, run_cmd_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, err;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, q;
    logic [4:0] press = 5'h00;
    wire [4:0] term_i;
    logic pready_o, pslverr_o, run3_o, stop3_o, dir3_o, jog_fwd_o, jog_rev_o, jog_stop_o;
    logic acc_set2_o, ramp_hold_o, run_alt_o, freq_alt_o, rapid_stop_o, base_block_o;
    logic bb_resume_o, pid_dis_o, fault_rst_o, auto_seq_o;
    logic [2:0] preset_idx_o;
    logic [15:0] preset_freq_o, preset_acc_o, preset_dec_o, bb_sweep_lo_o, bb_sweep_hi_o;
    logic [15:0] ud_freq_o;
    integer n_errors = 0, cmp_count = 0, scan = 1, n, k;
    always #50 clk_sys_i = ~clk_sys_i;
    dif_decoder #(.TICK_CYC(TICK)) u_dif_decoder (.clk_sys_i, .rst_b_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .term_i, .run_cmd_i,
        .run3_o, .stop3_o, .dir3_o, .preset_idx_o, .preset_freq_o, .preset_acc_o, .preset_dec_o,
        .jog_fwd_o, .jog_rev_o, .jog_stop_o, .acc_set2_o, .ramp_hold_o, .run_alt_o, .freq_alt_o,
        .rapid_stop_o, .base_block_o, .bb_resume_o, .bb_sweep_lo_o, .bb_sweep_hi_o, .pid_dis_o,
        .fault_rst_o, .auto_seq_o, .ud_freq_o);
    dif_switch_model u_dif_switch_model (.clk_i(clk_sys_i), .press_i(press), .term_o(term_i));
    task results;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
            if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // One idle edge after each transfer so no signal is driven twice in a step
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        begin
            psel_i <= 1'b1;
            pwrite_i <= wr;
            paddr_i <= a;
            pwdata_i <= d;
            @(posedge clk_sys_i);
            penable_i <= 1'b1;
            n = 0;
            do begin
                @(posedge clk_sys_i);
                n = n + 1;
            end while (pready_o !== 1'b1 && n < 20);
            q = prdata_o;
            err = pslverr_o;
            psel_i <= 1'b0;
            penable_i <= 1'b0;
            if (n >= 20) begin
                n_errors = n_errors + 1;
                results();
            end
            @(posedge clk_sys_i);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic e_err);
        begin
            apb(1'b0, a, 32'h0000_0000);
            chk(q, e);
            chk(err, e_err);
        end
    endtask
    function [31:0] fn(input [4:0] c0, input [4:0] c1, input [4:0] c2);
        fn = {17'h0_0000, c2, c1, c0};
    endfunction
    task settle;
        repeat ((scan + 3) * TICK + 8) @(posedge clk_sys_i);
    endtask
    task tap(input logic [4:0] b);
        begin
            press <= b;
            settle();
            press <= 5'h00;
            settle();
        end
    endtask
    task t_regs;
        begin
            rd_chk(`DIF_CTRL_OFS, 32'h0000_0000, 1'b0);
            rd_chk(`DIF_FUNC_OFS, 32'h0000_0000, 1'b0);
            rd_chk(`DIF_SCAN_OFS, 32'h0000_0001, 1'b0);
            rd_chk(`DIF_FMAX_OFS, 32'h0000_1770, 1'b0);
            rd_chk(8'hF0, 32'h0000_0000, 1'b1);
            wr(`DIF_STEP_OFS, 32'h0000_01F5);
            rd_chk(`DIF_STEP_OFS, 32'h0000_0001, 1'b0);
            wr(`DIF_STEP_OFS, 32'h0000_01F4);
            rd_chk(`DIF_STEP_OFS, 32'h0000_01F4, 1'b0);
            wr(`DIF_SCAN_OFS, 32'h0000_00C9);
            rd_chk(`DIF_SCAN_OFS, 32'h0000_0001, 1'b0);
            wr(`DIF_SCAN_OFS, 32'h0000_00C8);
            rd_chk(`DIF_SCAN_OFS, 32'h0000_00C8, 1'b0);
            wr(`DIF_SCAN_OFS, 32'h0000_0002);
            scan = 2;
            $display("test regs done");
        end
    endtask
    task t_preset;
        begin
            wr(`DIF_FUNC_OFS, fn(5'h02, 5'h03, 5'h04));
            for (k = 0; k < 8; k = k + 1) begin
                wr(`DIF_PFRQ_OFS + 8'(4 * k), 32'h0000_0100 + k);
                wr(`DIF_PACC_OFS + 8'(4 * k), 32'h0200_0300 + 32'h0001_0001 * k);
            end
            for (k = 0; k < 8; k = k + 1) begin
                press <= 5'(k);
                settle();
                chk(preset_idx_o, k);
                chk({preset_freq_o, preset_acc_o}, 32'h0100_0300 + 32'h0001_0001 * k);
                chk(preset_dec_o, 32'h0000_0200 + k);
            end
            press <= 5'h00;
            settle();
            $display("test preset done");
        end
    endtask
    task t_jog;
        begin
            wr(`DIF_FUNC_OFS, fn(5'h06, 5'h07, 5'h00));
            for (k = 1; k < 4; k = k + 1) begin
                press <= 5'(k);
                settle();
                chk({jog_fwd_o, jog_rev_o, jog_stop_o}, k == 3 ? 1 : 8 >> k);
            end
            press <= 5'h00;
            settle();
            $display("test jog done");
        end
    endtask
    task t_levels;
        begin
        for (k = 0; k < 6; k = k + 1) begin
            wr(`DIF_FUNC_OFS, fn(LV[5*k +: 5], 5'h00, 5'h00));
            press <= 5'h01;
            settle();
            chk({acc_set2_o, ramp_hold_o, run_alt_o, freq_alt_o, pid_dis_o, auto_seq_o},
                6'h20 >> k);
            press <= 5'h00;
            settle();
            chk({acc_set2_o, ramp_hold_o, run_alt_o, freq_alt_o, pid_dis_o, auto_seq_o}, 0);
        end
        $display("test levels done");
        end
    endtask
    task t_events;
        begin
            wr(`DIF_FUNC_OFS, fn(5'h0E, 5'h0F, 5'h11));
            press <= 5'h01;
            settle();
            chk({rapid_stop_o, acc_set2_o}, 3);
            press <= 5'h00;
            settle();
            chk(rapid_stop_o, 1);
            run_cmd_i <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            chk(rapid_stop_o, 0);
            press <= 5'h02;
            settle();
            chk(base_block_o, 1);
            press <= 5'h00;
            n = 0;
            repeat ((scan + 3) * TICK + 8) begin
                @(posedge clk_sys_i);
                n = n + bb_resume_o;
            end
            chk(n, 1);
            wr(`DIF_KPAD_OFS, 32'h0000_03E8);
            repeat (3) @(posedge clk_sys_i);
            chk({bb_sweep_lo_o, bb_sweep_hi_o}, 32'h01F4_05DC);
            wr(`DIF_KPAD_OFS, 32'h0000_00C8);
            repeat (3) @(posedge clk_sys_i);
            chk({bb_sweep_lo_o, bb_sweep_hi_o}, 32'h0000_02BC);
            press <= 5'h04;
            n = 0;
            repeat ((scan + 3) * TICK + 8) begin
                @(posedge clk_sys_i);
                n = n + fault_rst_o;
            end
            chk(n, 1);
            press <= 5'h00;
            settle();
            $display("test events done");
        end
    endtask
    task t_updown;
        begin
            wr(`DIF_STEP_OFS, 32'h0000_0064);
            wr(`DIF_FMAX_OFS, 32'h0000_00FA);
            wr(`DIF_FUNC_OFS, fn(5'h08, 5'h09, 5'h00));
            wr(`DIF_CTRL_OFS, 32'h0000_0008);
            tap(5'h02);
            chk(ud_freq_o, 0);
            for (k = 1; k < 4; k = k + 1) begin
                tap(5'h01);
                chk(ud_freq_o, k == 3 ? 250 : 100 * k);
            end
            for (k = 0; k < 3; k = k + 1) begin
                tap(5'h02);
                chk(ud_freq_o, k == 2 ? 0 : 150 - 100 * k);
            end
            wr(`DIF_FMAX_OFS, 32'h0000_1770);
            press <= 5'h01;
            repeat (1900 * TICK) @(posedge clk_sys_i);
            chk(ud_freq_o, 100);
            repeat (400 * TICK) @(posedge clk_sys_i);
            chk(ud_freq_o >= 16'h012C, 1);
            press <= 5'h00;
            wr(`DIF_CTRL_OFS, 32'h0000_0004);
            run_cmd_i <= 1'b0;
            repeat (4) @(posedge clk_sys_i);
            chk(ud_freq_o, 0);
            run_cmd_i <= 1'b1;
            wr(`DIF_CTRL_OFS, 32'h0000_0000);
            tap(5'h01);
            run_cmd_i <= 1'b0;
            repeat (4) @(posedge clk_sys_i);
            rd_chk(`DIF_KPAD_OFS, 32'h0000_0064, 1'b0);
            tap(5'h01);
            chk(ud_freq_o, 100);
            run_cmd_i <= 1'b1;
            wr(`DIF_CTRL_OFS, 32'h0000_0008);
            run_cmd_i <= 1'b0;
            tap(5'h01);
            chk(ud_freq_o, 200);
            $display("test updown done");
        end
    endtask
    task t_three;
        begin
            wr(`DIF_CTRL_OFS, 32'h0000_0002);
            wr(`DIF_FUNC_OFS, fn(5'h06, 5'h07, 5'h08));
            for (k = 0; k < 3; k = k + 1) begin
                press <= 5'(1 << k);
                settle();
                chk({run3_o, stop3_o, dir3_o, jog_fwd_o, jog_rev_o}, 5'h10 >> k);
                chk(ud_freq_o, 200);
            end
            press <= 5'h00;
            wr(`DIF_CTRL_OFS, 32'h0000_0000);
            $display("test three wire done");
        end
    endtask
    task t_pol;
        begin
            wr(`DIF_SCAN_OFS, 32'h0000_0005);
            scan = 5;
            wr(`DIF_FUNC_OFS, fn(5'h06, 5'h00, 5'h00));
            wr(`DIF_CTRL_OFS, 32'h0000_0010);
            settle();
            chk(jog_fwd_o, 1);
            press <= 5'h01;
            settle();
            chk(jog_fwd_o, 0);
            // Short release must be swallowed as noise
            press <= 5'h00;
            repeat (3) @(posedge clk_sys_i);
            press <= 5'h01;
            n = 0;
            repeat ((scan + 3) * TICK + 8) begin
                @(posedge clk_sys_i);
                n = n + jog_fwd_o;
            end
            chk(n, 0);
            $display("test polarity done");
        end
    endtask
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        @(posedge clk_sys_i);
        t_regs();
        t_preset();
        t_jog();
        t_levels();
        t_events();
        t_updown();
        t_three();
        t_pol();
        results();
    end
endmodule // dif_decoder_tb
